// ---- hdl/fpes_sequencer.sv ----
// Purpose: Flash program/erase sequencer with key lock, stall and block write
// Assumes: Core, debug port and register port share clk; core honours stall
// Notes:   Flash array held here; code reads return one cycle after address
`timescale 1ns/1ps
module fpes_sequencer #(
    parameter int FLASH_BYTES = fpes_pkg::FLASH_BYTES,
    parameter int ERASE_CYC   = fpes_pkg::ERASE_CYC
) (
    input  wire logic               clk,
    input  wire logic               sys_rst,
    input  wire logic [2:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic [7:0]              reg_rdata,
    input  wire fpes_pkg::fpes_move_s mv,
    output fpes_pkg::fpes_ext_s     ext_ram,
    input  wire logic [15:0]        code_addr,
    output logic [7:0]              code_rdata,
    input  wire fpes_pkg::fpes_dbg_s dbg,
    output logic                    cpu_stall
);
    localparam int FA_W = $clog2(FLASH_BYTES);
    localparam int TW   = $clog2(ERASE_CYC + 1);
    localparam int PW   = fpes_pkg::PAGE_SHIFT;

    // Elaboration check; the page sweep needs at least two pages of address
    if (FLASH_BYTES % fpes_pkg::PAGE_BYTES != 0 || FLASH_BYTES > 65536 ||
        FLASH_BYTES < 2 * fpes_pkg::PAGE_BYTES || (1 << FA_W) != FLASH_BYTES ||
        ERASE_CYC < 1 || fpes_pkg::PROG_CYC >= ERASE_CYC) begin : g_bad_params
        $error("fpes_sequencer: unsupported parameters");
    end

    logic [7:0]          mem [FLASH_BYTES];
    fpes_pkg::fpes_key_e key_st;
    fpes_pkg::fpes_op_e  op_st;
    logic                st_we_r, st_ee_r, te_r, bw_r;
    logic                cache_v_r;
    logic [FA_W-1:0]     cache_a_r, op_a_r;
    logic [7:0]          cache_d_r, op_d_r, d2_r;
    logic                pend2_r, sweep_r;
    logic [PW-1:0]       idx_r;
    logic [TW-1:0]       timer_r;
    logic                fw, fw_bad, fw_ok, accept, kw;
    logic                go_erase, go_cache, go_prog, go_pair, dbg_go;
    logic                mem_we;
    logic [FA_W-1:0]     mem_wa;
    logic [7:0]          mem_wd;

    // Decode of a redirected move write; only looked at while idle
    always_comb begin
        kw       = reg_wr && reg_addr == fpes_pkg::REG_KEY;
        fw       = mv.wr && st_we_r && op_st == fpes_pkg::OP_IDLE;
        fw_bad   = fw && mv.addr8 && mv.addr > fpes_pkg::MOVE8_MAX;
        fw_ok    = fw && !fw_bad;
        accept   = fw_ok && key_st == fpes_pkg::KEY_OPEN;
        go_erase = accept && st_ee_r;
        go_cache = accept && !st_ee_r && bw_r && !cache_v_r;
        go_prog  = accept && !st_ee_r && !go_cache;
        go_pair  = go_prog && bw_r &&
                   mv.addr[FA_W-1:0] == FA_W'(cache_a_r + 1'b1);
        dbg_go   = dbg.wr && op_st == fpes_pkg::OP_IDLE && !accept;
    end

    // Key lock: dead state is left only by reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            key_st <= fpes_pkg::KEY_LOCKED;
        end else if (key_st == fpes_pkg::KEY_DEAD) begin
            key_st <= fpes_pkg::KEY_DEAD;
        end else if (fw_ok && key_st != fpes_pkg::KEY_OPEN) begin
            key_st <= fpes_pkg::KEY_DEAD;
        end else if (accept) begin
            key_st <= fpes_pkg::KEY_LOCKED;
        end else if (kw) begin
            case (key_st)
                fpes_pkg::KEY_LOCKED: begin
                    key_st <= (reg_wdata == fpes_pkg::KEY_CODE_1) ?
                              fpes_pkg::KEY_ARMED : fpes_pkg::KEY_DEAD;
                end
                fpes_pkg::KEY_ARMED: begin
                    key_st <= (reg_wdata == fpes_pkg::KEY_CODE_2) ?
                              fpes_pkg::KEY_OPEN : fpes_pkg::KEY_DEAD;
                end
                default: begin
                    key_st <= fpes_pkg::KEY_DEAD;                       // Extra code is out of order
                end
            endcase
        end
    end

    // Software registers; enables hold until software clears them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_we_r <= fpes_pkg::CTRL_RST[fpes_pkg::CTRL_WE_BIT];
            st_ee_r <= fpes_pkg::CTRL_RST[fpes_pkg::CTRL_EE_BIT];
            te_r    <= fpes_pkg::SCALE_RST[fpes_pkg::SCALE_TE_BIT];
            bw_r    <= fpes_pkg::CACHE_RST[fpes_pkg::CACHE_BW_BIT];
        end else if (reg_wr) begin
            if (reg_addr == fpes_pkg::REG_CTRL) begin
                st_we_r <= reg_wdata[fpes_pkg::CTRL_WE_BIT];
                st_ee_r <= reg_wdata[fpes_pkg::CTRL_EE_BIT];
            end
            if (reg_addr == fpes_pkg::REG_SCALE) begin
                te_r <= reg_wdata[fpes_pkg::SCALE_TE_BIT];
            end
            if (reg_addr == fpes_pkg::REG_CACHE) begin
                bw_r <= reg_wdata[fpes_pkg::CACHE_BW_BIT];
            end
        end
    end

    // Read data appear one cycle after the strobe, zero otherwise
    always_ff @(posedge clk) begin
        if (sys_rst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            case (reg_addr)
                fpes_pkg::REG_KEY:   reg_rdata <= {6'h00, key_st};
                fpes_pkg::REG_CTRL:  reg_rdata <= {6'h00, st_ee_r, st_we_r};
                fpes_pkg::REG_SCALE: reg_rdata <= {3'h0, te_r, 4'h0};
                fpes_pkg::REG_CACHE: reg_rdata <= {7'h00, bw_r};
                fpes_pkg::REG_STAT:  reg_rdata <= {4'h0, cpu_stall, cache_v_r,
                                                   key_st == fpes_pkg::KEY_DEAD,
                                                   key_st == fpes_pkg::KEY_OPEN};
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

    // Block-write cache; dropped as soon as the mode is abandoned
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cache_v_r <= 1'b0;
            cache_a_r <= '0;
            cache_d_r <= 8'h00;
        end else if (!bw_r || !st_we_r || go_erase || go_prog) begin
            cache_v_r <= 1'b0;
        end else if (go_cache) begin
            cache_v_r <= 1'b1;
            cache_a_r <= mv.addr[FA_W-1:0];
            cache_d_r <= mv.data;
        end
    end

    // Operation timer and stall; a pair takes one program time plus a cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            op_st     <= fpes_pkg::OP_IDLE;
            cpu_stall <= 1'b0;
            timer_r   <= '0;
            op_a_r    <= '0;
            op_d_r    <= 8'h00;
            d2_r      <= 8'h00;
            pend2_r   <= 1'b0;
            sweep_r   <= 1'b0;
            idx_r     <= '0;
        end else begin
            case (op_st)
                fpes_pkg::OP_IDLE: begin
                    sweep_r <= 1'b0;
                    idx_r   <= '0;
                    if (go_erase) begin
                        op_st     <= fpes_pkg::OP_ERASE;
                        cpu_stall <= 1'b1;
                        timer_r   <= TW'(ERASE_CYC - 1);
                        op_a_r    <= mv.addr[FA_W-1:0];
                    end else if (go_prog || dbg_go) begin
                        op_st     <= fpes_pkg::OP_PROG;
                        cpu_stall <= 1'b1;
                        timer_r   <= TW'(fpes_pkg::PROG_CYC - 1);
                        pend2_r   <= go_pair;
                        d2_r      <= mv.data;
                        if (go_pair) begin
                            op_a_r <= cache_a_r;
                            op_d_r <= cache_d_r;
                        end else if (go_prog) begin
                            op_a_r <= mv.addr[FA_W-1:0];
                            op_d_r <= mv.data;
                        end else begin
                            op_a_r <= dbg.addr[FA_W-1:0];
                            op_d_r <= dbg.data;
                        end
                    end
                end
                fpes_pkg::OP_PROG: begin
                    if (timer_r != '0) begin
                        timer_r <= timer_r - 1'b1;
                    end else if (pend2_r) begin
                        pend2_r <= 1'b0;                                // Second byte next cycle
                        op_a_r  <= FA_W'(op_a_r + 1'b1);
                        op_d_r  <= d2_r;
                    end else begin
                        op_st     <= fpes_pkg::OP_IDLE;
                        cpu_stall <= 1'b0;
                    end
                end
                fpes_pkg::OP_ERASE: begin
                    if (!sweep_r) begin
                        timer_r <= timer_r - 1'b1;
                        sweep_r <= timer_r == '0;
                    end else begin
                        idx_r <= idx_r + 1'b1;
                        if (&idx_r) begin
                            op_st     <= fpes_pkg::OP_IDLE;
                            cpu_stall <= 1'b0;
                        end
                    end
                end
                default: begin
                    op_st     <= fpes_pkg::OP_IDLE;
                    cpu_stall <= 1'b0;
                end
            endcase
        end
    end

    // Array write port: programming ANDs into the old byte
    always_comb begin
        mem_we = (op_st == fpes_pkg::OP_PROG && timer_r == '0) ||
                 (op_st == fpes_pkg::OP_ERASE && sweep_r);
        if (op_st == fpes_pkg::OP_ERASE) begin
            mem_wa = {op_a_r[FA_W-1:PW], idx_r};
            mem_wd = fpes_pkg::ERASED_BYTE;
        end else begin
            mem_wa = op_a_r;
            mem_wd = mem[op_a_r] & op_d_r;
        end
    end

    // Flash array has no reset: its contents are non-volatile
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Code-move reads of the flash, one cycle latency
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code_rdata <= 8'h00;
        end else begin
            code_rdata <= mem[code_addr[FA_W-1:0]];
        end
    end

    // External RAM side: reads always, writes only when not redirected
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_ram <= '0;
        end else begin
            ext_ram.we   <= mv.wr && !st_we_r;
            ext_ram.re   <= mv.rd;
            ext_ram.addr <= mv.addr;
            ext_ram.data <= mv.data;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_arm;
        kw && reg_wdata == fpes_pkg::KEY_CODE_1 && key_st == fpes_pkg::KEY_LOCKED;
    endsequence
    sequence s_open;
        kw && reg_wdata == fpes_pkg::KEY_CODE_2 && key_st == fpes_pkg::KEY_ARMED && !fw;
    endsequence

    a_key_arming: assert property (s_arm |=> key_st == fpes_pkg::KEY_ARMED)
        else $error("first key code did not arm");
    a_key_opening: assert property (s_open |=> key_st == fpes_pkg::KEY_OPEN)
        else $error("second key code did not unlock");
    a_bad_key: assert property (kw && key_st == fpes_pkg::KEY_ARMED &&
        reg_wdata != fpes_pkg::KEY_CODE_2 && !fw |=> key_st == fpes_pkg::KEY_DEAD)
        else $error("wrong second key code not punished");
    a_dead_sticks: assert property (key_st == fpes_pkg::KEY_DEAD |=>
        key_st == fpes_pkg::KEY_DEAD && $stable(key_st))
        else $error("lockout left without reset");
    a_early_write: assert property (fw_ok && key_st != fpes_pkg::KEY_OPEN
        |=> key_st == fpes_pkg::KEY_DEAD)
        else $error("flash write without key not locked out");
    a_relock_op: assert property (accept |=> key_st == fpes_pkg::KEY_LOCKED ##1
        key_st != fpes_pkg::KEY_OPEN)
        else $error("lock not restored after operation");
    a_stall_busy: assert property ((op_st != fpes_pkg::OP_IDLE) == cpu_stall)
        else $error("stall does not cover operation");
    a_prog_time: assert property (go_prog && !dbg_go |=> cpu_stall [*8])
        else $error("program ended too early");
    a_erase_ff: assert property (mem_we && op_st == fpes_pkg::OP_ERASE
        |-> mem_wd == fpes_pkg::ERASED_BYTE && mem_wa[PW-1:0] == idx_r)
        else $error("erase wrote non-erased value");
    a_move8_range: assert property (fw_bad |=> op_st == fpes_pkg::OP_IDLE &&
        key_st == $past(key_st))
        else $error("8-bit move above FF touched flash");
    a_read_ram: assert property (mv.rd |=> ext_ram.re)
        else $error("move read not sent to external RAM");
    a_no_redirect: assert property (mv.wr && st_we_r |=> !ext_ram.we)
        else $error("redirected write reached external RAM");
endmodule // fpes_sequencer

// ---- hdl/fpes_pkg.sv ----
// Purpose: Shared constants and types for the flash program/erase sequencer
// Assumes: 40 MHz system clock, byte-wide register port
// Notes:   Times are kept in their own unit; cycle counts derive from them
package fpes_pkg;
    // Register port map (index on reg_addr)
    localparam logic [2:0] REG_KEY   = 3'h0;
    localparam logic [2:0] REG_CTRL  = 3'h1;
    localparam logic [2:0] REG_SCALE = 3'h2;
    localparam logic [2:0] REG_CACHE = 3'h3;
    localparam logic [2:0] REG_STAT  = 3'h4;
    // Field positions
    localparam int CTRL_WE_BIT  = 0;
    localparam int CTRL_EE_BIT  = 1;
    localparam int SCALE_TE_BIT = 4;
    localparam int CACHE_BW_BIT = 0;
    // Reset values
    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] SCALE_RST = 8'h00;
    localparam logic [7:0] CACHE_RST = 8'h00;
    // Key codes and flash geometry
    localparam logic [7:0]  KEY_CODE_1  = 8'hA5;
    localparam logic [7:0]  KEY_CODE_2  = 8'hF1;
    localparam logic [7:0]  ERASED_BYTE = 8'hFF;
    localparam logic [15:0] MOVE8_MAX   = 16'h00FF;
    localparam int          PAGE_SHIFT  = 9;
    localparam int          PAGE_BYTES  = 512;
    localparam int          FLASH_BYTES = 16384;
    // Timing
    localparam int CLK_MHZ       = 40;
    localparam int PROG_TIME_NS  = 40000;
    localparam int ERASE_TIME_US = 20000;
    localparam int PROG_CYC      = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int ERASE_CYC     = ERASE_TIME_US * CLK_MHZ;
    // Key and operation states
    typedef enum logic [1:0] {KEY_LOCKED, KEY_ARMED, KEY_OPEN, KEY_DEAD} fpes_key_e;
    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} fpes_op_e;
    // Core move-instruction request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        addr8;
        logic [15:0] addr;
        logic [7:0]  data;
    } fpes_move_s;
    // External data RAM access
    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  data;
    } fpes_ext_s;
    // Debug-port byte write
    typedef struct packed {
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } fpes_dbg_s;
endpackage

// ---- test/fpes_core_model.sv ----
// Purpose: Core-side model issuing external move instructions
// Assumes: Core halts while cpu_stall is high and changes pins after a rising edge
// Notes:   Released address and data lines show inverted values, not stale ones
`timescale 1ns/1ps
module fpes_core_model (
    input  wire logic           clk,
    input  wire logic           cpu_stall,
    output fpes_pkg::fpes_move_s mv
);
    initial mv = '0;

    // One move instruction; a stalled core cannot fetch, so it waits first
    task automatic mv_op(input logic wr, input logic a8, input logic [15:0] addr,
                         input logic [7:0] data);
        @(posedge clk);
        while (cpu_stall === 1'b1) @(posedge clk);
        mv <= '{wr: wr, rd: !wr, addr8: a8, addr: addr, data: data};
        @(posedge clk);
        mv <= '{wr: 1'b0, rd: 1'b0, addr8: 1'b0, addr: ~addr, data: ~data};
    endtask
endmodule // fpes_core_model

// ---- test/fpes_sequencer_tb.sv ----
// Purpose: Self-checking bench for the flash program/erase sequencer
// Assumes: Erase shortened through ERASE_CYC; program time kept at full length
// Notes:   Read results are queued by the driver and compared by a monitor
`timescale 1ns/1ps
module fpes_sequencer_tb;
    localparam int ERASE_CYC = 1700;
    localparam int PROG_LEN  = fpes_pkg::PROG_CYC;
    logic                 clk, sys_rst, reg_wr, reg_rd, cr, rd_d, cr_d, cpu_stall;
    logic [2:0]           reg_addr;
    logic [7:0]           reg_wdata, reg_rdata, code_rdata, d1, d2;
    logic [15:0]          code_addr;
    logic [15:0]          bad_keys [3] = '{16'hF1A5, 16'hA500, 16'hA5A5};
    fpes_pkg::fpes_move_s mv;
    fpes_pkg::fpes_ext_s  ext_ram;
    fpes_pkg::fpes_dbg_s  dbg;
    int                   err_total, checked, cyc, seed, n;
    logic [7:0]           exp_q [$];
    string                what_q [$];

    fpes_sequencer #(.ERASE_CYC(ERASE_CYC)) fpes_sequencer_inst (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mv(mv), .ext_ram(ext_ram),
        .code_addr(code_addr), .code_rdata(code_rdata), .dbg(dbg), .cpu_stall(cpu_stall));
    fpes_core_model fpes_core_model_inst (.clk(clk), .cpu_stall(cpu_stall), .mv(mv));

    // Clock and time-zero values
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, cr, rd_d, cr_d} = 6'h20;
        {reg_addr, reg_wdata, code_addr} = '0;
        dbg = '0;
        {err_total, checked, cyc} = '0;
        seed = 32'h005133C7;
    end

    task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", w, e, g);
            err_total++;
        end
    endtask

    task automatic end_sim();
        if (err_total == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard; a full run needs about 10400 cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            end_sim();
        end
    end

    // Register results stand only in the cycle after their strobe, so compare there
    always @(posedge clk) begin
        rd_d <= reg_rd;
        cr_d <= cr;
        if (rd_d || cr_d) begin
            chk(what_q.pop_front(), {8'h00, exp_q.pop_front()},
                {8'h00, rd_d ? reg_rdata : code_rdata});
        end
    end

    task automatic rw(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rr(input logic [2:0] a, input logic [7:0] e, input string w);
        exp_q.push_back(e);
        what_q.push_back(w);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask

    task automatic cread(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        what_q.push_back("code_rdata");
        @(posedge clk);
        code_addr <= a;
        cr        <= 1'b1;
        @(posedge clk);
        cr        <= 1'b0;
    endtask

    task automatic key();
        rw(fpes_pkg::REG_KEY, fpes_pkg::KEY_CODE_1);
        rw(fpes_pkg::REG_KEY, fpes_pkg::KEY_CODE_2);
    endtask

    // Counts stalled cycles; gives up early if stall never rises
    task automatic stall_len(input int e);
        n = 0;
        for (int i = 0; i < 5000; i++) begin
            @(posedge clk);
            if (cpu_stall === 1'b1) n++;
            else if (n > 0 || i > 3) break;
        end
        chk("cpu_stall_cycles", e[15:0], n[15:0]);
    endtask

    task automatic rst();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
    endtask

    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        // Reset values, index 5 unmapped
        for (int a = 0; a < 6; a++) rr(a[2:0], 8'h00, "reset_value");
        // Page erase from an address in the middle of page 1
        rw(fpes_pkg::REG_SCALE, 8'h10);
        rr(fpes_pkg::REG_SCALE, 8'h10, "scale_reg");
        rw(fpes_pkg::REG_CTRL, 8'h03);
        rw(fpes_pkg::REG_KEY, fpes_pkg::KEY_CODE_1);
        rr(fpes_pkg::REG_KEY, 8'h01, "key_state");
        rw(fpes_pkg::REG_KEY, fpes_pkg::KEY_CODE_2);
        rr(fpes_pkg::REG_KEY, 8'h02, "key_state");
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h03A7, 8'h5A);
        stall_len(ERASE_CYC + fpes_pkg::PAGE_BYTES);
        rr(fpes_pkg::REG_KEY, 8'h00, "key_state");
        cread(16'h0200, 8'hFF);
        cread(16'h03FF, 8'hFF);
        // Single bytes; 8-bit move above FF must leave the key open
        rw(fpes_pkg::REG_CTRL, 8'h01);
        key();
        fpes_core_model_inst.mv_op(1'b1, 1'b1, 16'h0300, d1);
        stall_len(0);
        rr(fpes_pkg::REG_KEY, 8'h02, "key_state");
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0234, d1);
        stall_len(PROG_LEN);
        cread(16'h0234, d1);
        cread(16'h0235, 8'hFF);
        key();
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0234, d2);
        stall_len(PROG_LEN);
        cread(16'h0234, d1 & d2);
        // Move reads go to RAM; writes too once the enable is cleared
        fpes_core_model_inst.mv_op(1'b0, 1'b0, 16'h0234, 8'h00);
        @(posedge clk);
        chk("ext_ram_rd_addr", 16'h0234, ext_ram.re ? ext_ram.addr : 16'hDEAD);
        rw(fpes_pkg::REG_CTRL, 8'h00);
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0123, 8'h3C);
        @(posedge clk);
        chk("ext_ram_wr_addr", 16'h0123, ext_ram.we ? ext_ram.addr : 16'hDEAD);
        chk("ext_ram_wr_data", 16'h003C, {8'h00, ext_ram.data});
        // Block write: pair commits together, a broken pair drops the cache
        rw(fpes_pkg::REG_CACHE, 8'h01);
        rw(fpes_pkg::REG_CTRL, 8'h01);
        key();
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0240, d1);
        stall_len(0);
        rr(fpes_pkg::REG_STAT, 8'h04, "cache_status");
        key();
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0241, d2);
        stall_len(PROG_LEN + 1);
        cread(16'h0240, d1);
        cread(16'h0241, d2);
        key();
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0260, d1);
        stall_len(0);
        key();
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0270, d2);
        stall_len(PROG_LEN);
        cread(16'h0260, 8'hFF);
        cread(16'h0270, d2);
        // Write without key locks software out; debug port still works
        rw(fpes_pkg::REG_CACHE, 8'h00);
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0280, d1);
        stall_len(0);
        key();
        rr(fpes_pkg::REG_KEY, 8'h03, "key_state");
        fpes_core_model_inst.mv_op(1'b1, 1'b0, 16'h0280, d1);
        stall_len(0);
        @(posedge clk);
        dbg <= '{wr: 1'b1, addr: 16'h0280, data: d2};
        @(posedge clk);
        dbg <= '{wr: 1'b0, addr: 16'hFD7F, data: ~d2};
        repeat (PROG_LEN + 2) @(posedge clk);
        cread(16'h0280, d2);
        // Bad key pairs, each cleared only by a mid-run reset
        for (int k = 0; k < 3; k++) begin
            rst();
            rr(fpes_pkg::REG_KEY, 8'h00, "key_state");
            rw(fpes_pkg::REG_KEY, bad_keys[k][15:8]);
            rw(fpes_pkg::REG_KEY, bad_keys[k][7:0]);
            rr(fpes_pkg::REG_KEY, 8'h03, "key_state");
        end
        repeat (4) @(posedge clk);
        end_sim();
    end
endmodule // fpes_sequencer_tb
